// ===== lpcs_luma_capture.sv
// luma processing path with capture format and crop origin setup
// assumes an axi4-lite master, a pixel source with line and field pulses
// between pixels, and a sink that drains the output stream
`timescale 1ns/10ps
`include "lpcs_params.svh"
// What this block does
// - coring turns samples below n/256 black
// - three manual lowpass levels, or none
// - auto lowpass chooses level from width
// - gamma 2.2 ntsc, 2.8 pal for rgb
// - never gamma correct ycrcb output
// - comb averages luma with previous line
// - four sharpening levels, level0 strongest
// - format change waits one full field
// - capture of other format switches format
// - crop origin snapped, applied value read
module lpcs_luma_capture (
  input logic aclk,
  input logic aresetn,
  input logic s_awvalid,
  output logic s_awready,
  input logic [7:0] s_awaddr,
  input logic s_wvalid,
  output logic s_wready,
  input logic [31:0] s_wdata,
  input logic [3:0] s_wstrb,
  output logic s_bvalid,
  input logic s_bready,
  output logic [1:0] s_bresp,
  input logic s_arvalid,
  output logic s_arready,
  input logic [7:0] s_araddr,
  output logic s_rvalid,
  input logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  input logic vid_valid,
  output logic vid_ready,
  input logic [7:0] vid_luma,
  input logic vid_line_start,
  input logic vid_field_start,
  output logic out_valid,
  input logic out_ready,
  output lpcs_pkg::lpcs_pix_s out_pixel
);
  // bus holding registers
  logic aw_hold_r;  // address waiting
  logic [7:0] aw_addr_r;
  logic w_hold_r;  // data waiting
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_fire;  // both halves present
  logic wr_hit;  // mapped write address
  // control and status state
  lpcs_pkg::lpcs_luma_s luma_r;  // luma control fields
  lpcs_pkg::lpcs_fmt_e fmt_r;  // active pixel format
  logic pal_r;  // standard is pal or secam
  logic [`LPCS_COL_W-1:0] crop_r;  // applied crop origin
  logic [1:0] cap_fmt_r;  // last capture destination format
  logic [`LPCS_WID_W-1:0] width_r;  // capture width
  lpcs_pkg::lpcs_st_e st_r;  // settling state
  logic cap_pend_r;  // capture waiting for field
  logic cap_act_r;  // capture field running
  // write data merged with byte lanes
  logic [15:0] wmask;
  logic [15:0] wd_luma;
  logic [15:0] wd_fmt;
  logic [15:0] wd_crop;
  logic [15:0] wd_cap;
  logic [15:0] wd_wid;
  logic wr_luma;
  logic wr_fmt;
  logic wr_crop;
  logic wr_cap;
  logic wr_wid;
  logic fmt_chg;  // format change request
  lpcs_pkg::lpcs_fmt_e fmt_new;
  logic [16:0] crop_snap;
  // video path
  logic acc;  // pixel taken
  logic keep;  // pixel goes to the output
  logic [`LPCS_COL_W-1:0] col_r;  // column of next pixel
  logic [`LPCS_COL_W-1:0] raddr;
  logic [7:0] prev_line;  // same column, previous line
  logic [7:0] x1_r;
  logic [7:0] x2_r;
  logic [7:0] x3_r;
  logic [7:0] x4_r;
  logic [2:0] lp_eff;
  logic [7:0] lp_y;
  logic [7:0] pk_y;
  logic [7:0] cb_y;
  logic [7:0] cr_y;
  logic [7:0] gm_y;
  lpcs_pkg::lpcs_pix_s pix;
  logic fifo_in_ready;
  logic [2:0] fifo_level;

  // piecewise linear gamma from a nine knot table
  function automatic logic [7:0] gam(input logic [7:0] y, input logic [71:0] t);
    logic [3:0] i;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [12:0] p;
    i = {1'h0, y[7:5]};
    b0 = t[{i, 3'h0} +: 8];
    b1 = t[{4'(i + 4'h1), 3'h0} +: 8];
    p = 13'(8'(b1 - b0)) * 13'(y[4:0]);
    return 8'(b0 + p[12:5]);
  endfunction

  assign s_awready = !aw_hold_r && !bvalid_r;
  assign s_wready = !w_hold_r && !bvalid_r;
  assign s_bvalid = bvalid_r;
  assign s_bresp = bresp_r;
  assign s_arready = !rvalid_r;
  assign s_rvalid = rvalid_r;
  assign s_rdata = rdata_r;
  assign s_rresp = rresp_r;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;

  // write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'h0;
      aw_addr_r <= '0;
    end else if (s_awvalid && s_awready) begin
      aw_hold_r <= 1'h1;
      aw_addr_r <= s_awaddr;
    end else if (wr_fire) begin
      aw_hold_r <= 1'h0;
    end
  end

  // write data capture, either order with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'h0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_wvalid && s_wready) begin
      w_hold_r <= 1'h1;
      w_data_r <= s_wdata;
      w_strb_r <= s_wstrb;
    end else if (wr_fire) begin
      w_hold_r <= 1'h0;
    end
  end

  // write decode
  assign wr_luma = wr_fire && (aw_addr_r == `LPCS_A_LUMA);
  assign wr_fmt = wr_fire && (aw_addr_r == `LPCS_A_FMT);
  assign wr_crop = wr_fire && (aw_addr_r == `LPCS_A_CROP);
  assign wr_cap = wr_fire && (aw_addr_r == `LPCS_A_CAP);
  assign wr_wid = wr_fire && (aw_addr_r == `LPCS_A_WIDTH);
  assign wr_hit = wr_luma || wr_fmt || wr_crop || wr_cap || wr_wid
    || (aw_addr_r == `LPCS_A_STAT);
  assign wmask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wd_luma = (16'(luma_r) & ~wmask) | (w_data_r[15:0] & wmask);
  assign wd_fmt = (16'({pal_r, fmt_r}) & ~wmask) | (w_data_r[15:0] & wmask);
  assign wd_crop = (16'(crop_r) & ~wmask) | (w_data_r[15:0] & wmask);
  assign wd_cap = (16'(cap_fmt_r) & ~wmask) | (w_data_r[15:0] & wmask);
  assign wd_wid = (16'(width_r) & ~wmask) | (w_data_r[15:0] & wmask);

  // write response, error on unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'h0;
      bresp_r <= `LPCS_RESP_OK;
    end else if (wr_fire) begin
      bvalid_r <= 1'h1;
      bresp_r <= wr_hit ? `LPCS_RESP_OK : `LPCS_RESP_ERR;
    end else if (s_bready) begin
      bvalid_r <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      luma_r <= '0;
    end else if (wr_luma) begin
      luma_r <= lpcs_pkg::lpcs_luma_s'(wd_luma[`LPCS_LUMA_W-1:0]);
    end
  end

  // crop snapped to nearest position
  // round half up, then drop the two low bits
  assign crop_snap = (17'(wd_crop) + `LPCS_CROP_HALF) & `LPCS_CROP_MASK;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crop_r <= '0;
    end else if (wr_crop) begin
      crop_r <= (crop_snap > `LPCS_CROP_MAX) ? `LPCS_COL_W'(`LPCS_CROP_MAX)
        : crop_snap[`LPCS_COL_W-1:0];
    end
  end

  // capture width and destination format
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      width_r <= `LPCS_AUTO_W1;
      cap_fmt_r <= '0;
    end else begin
      if (wr_wid) begin
        width_r <= wd_wid[`LPCS_WID_W-1:0];
      end
      if (wr_cap) begin
        cap_fmt_r <= wd_cap[1:0];
      end
    end
  end

  assign fmt_new = wr_cap ? lpcs_pkg::lpcs_fmt_e'(wd_cap[1:0])
    : lpcs_pkg::lpcs_fmt_e'(wd_fmt[1:0]);
  assign fmt_chg = (wr_cap || wr_fmt) && (fmt_new != fmt_r);

  // active format and video standard
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fmt_r <= lpcs_pkg::LPCS_FMT_RGB32;
      pal_r <= 1'h0;
    end else begin
      if (fmt_chg) begin
        fmt_r <= fmt_new;
      end
      if (wr_fmt) begin
        pal_r <= wd_fmt[2];
      end
    end
  end

  // drop pixels for the rest of the field and one whole field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= lpcs_pkg::LPCS_ST_RUN;
    end else if (fmt_chg) begin
      st_r <= lpcs_pkg::LPCS_ST_ALIGN;
    end else begin
      case (st_r)
        // running in the current format
        lpcs_pkg::LPCS_ST_RUN: st_r <= lpcs_pkg::LPCS_ST_RUN;
        // wait for a field boundary
        lpcs_pkg::LPCS_ST_ALIGN: begin
          if (vid_field_start) begin
            st_r <= lpcs_pkg::LPCS_ST_SETTLE;
          end
        end
        // one full field passes
        lpcs_pkg::LPCS_ST_SETTLE: begin
          if (vid_field_start) begin
            st_r <= lpcs_pkg::LPCS_ST_RUN;
          end
        end
        default: st_r <= lpcs_pkg::LPCS_ST_ALIGN;
      endcase
    end
  end

  // capture pending and active, a new request wins over the start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_pend_r <= 1'h0;
      cap_act_r <= 1'h0;
    end else begin
      if (vid_field_start) begin
        cap_act_r <= cap_pend_r && !fmt_chg && (st_r != lpcs_pkg::LPCS_ST_ALIGN);
      end
      if (wr_cap) begin
        cap_pend_r <= 1'h1;
      end else if (vid_field_start && !fmt_chg && (st_r != lpcs_pkg::LPCS_ST_ALIGN)) begin
        cap_pend_r <= 1'h0;
      end
    end
  end

  // register read with error on unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'h0;
      rdata_r <= '0;
      rresp_r <= `LPCS_RESP_OK;
    end else if (s_arvalid && s_arready) begin
      rvalid_r <= 1'h1;
      rresp_r <= `LPCS_RESP_OK;
      case (s_araddr)
        `LPCS_A_LUMA: rdata_r <= 32'(luma_r);
        `LPCS_A_FMT: rdata_r <= 32'({pal_r, fmt_r});
        `LPCS_A_CROP: rdata_r <= 32'(crop_r);
        `LPCS_A_CAP: rdata_r <= 32'(cap_fmt_r);
        `LPCS_A_WIDTH: rdata_r <= 32'(width_r);
        `LPCS_A_STAT: begin
          rdata_r <= 32'({fifo_level, cap_act_r, cap_pend_r,
            (st_r != lpcs_pkg::LPCS_ST_RUN)});
        end
        default: begin
          rdata_r <= '0;
          rresp_r <= `LPCS_RESP_ERR;
        end
      endcase
    end else if (s_rready) begin
      rvalid_r <= 1'h0;
    end
  end

  // pixel acceptance follows fifo room
  assign acc = vid_valid && vid_ready;
  assign vid_ready = fifo_in_ready;

  // column count, reset between lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      col_r <= '0;
    end else if (vid_line_start) begin
      col_r <= '0;
    end else if (acc) begin
      col_r <= col_r + `LPCS_COL_W'(1);
    end
  end

  // prefetch the previous line at the next column
  assign raddr = vid_line_start ? '0 : (acc ? col_r + `LPCS_COL_W'(1) : col_r);

  // horizontal history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x1_r <= '0;
      x2_r <= '0;
      x3_r <= '0;
      x4_r <= '0;
    end else if (acc) begin
      x1_r <= vid_luma;
      x2_r <= x1_r;
      x3_r <= x2_r;
      x4_r <= x3_r;
    end
  end

  always_comb begin
    lp_eff = luma_r.lp;
    if (luma_r.lp == lpcs_pkg::LPCS_LP_AUTO) begin
      if (width_r >= `LPCS_AUTO_W1) begin
        lp_eff = lpcs_pkg::LPCS_LP_NONE;
      end else if (width_r >= `LPCS_AUTO_W2) begin
        lp_eff = lpcs_pkg::LPCS_LP_L1;
      end else if (width_r >= `LPCS_AUTO_W3) begin
        lp_eff = lpcs_pkg::LPCS_LP_L2;
      end else begin
        lp_eff = lpcs_pkg::LPCS_LP_L3;
      end
    end
  end

  always_comb begin
    case (lp_eff)
      lpcs_pkg::LPCS_LP_L1: lp_y = 8'((9'(vid_luma) + 9'(x1_r)) >> 1);
      lpcs_pkg::LPCS_LP_L2: begin
        lp_y = 8'((10'(vid_luma) + {1'h0, x1_r, 1'h0} + 10'(x2_r)) >> 2);
      end
      lpcs_pkg::LPCS_LP_L3: begin
        lp_y = 8'((11'(vid_luma) + 11'({x1_r, 1'h0}) + 11'({x2_r, 1'h0})
          + 11'({x3_r, 1'h0}) + 11'(x4_r)) >> 3);
      end
      default: lp_y = vid_luma;
    endcase
  end

  always_comb begin
    logic signed [9:0] diff;
    logic signed [9:0] boost;
    logic signed [9:0] sum;
    diff = '0;
    boost = '0;
    sum = '0;
    diff = $signed({2'h0, vid_luma}) - $signed({2'h0, x1_r});
    case (luma_r.peak)
      lpcs_pkg::LPCS_PK_L0: boost = diff;
      lpcs_pkg::LPCS_PK_L1: boost = diff >>> 1;
      lpcs_pkg::LPCS_PK_L2: boost = diff >>> 2;
      lpcs_pkg::LPCS_PK_L3: boost = diff >>> 3;
      default: boost = '0;
    endcase
    sum = $signed({2'h0, lp_y}) + boost;
    if (sum < 0) begin
      pk_y = '0;
    end else if (sum > $signed(`LPCS_LUMA_MAX)) begin
      pk_y = 8'(`LPCS_LUMA_MAX);
    end else begin
      pk_y = sum[7:0];
    end
  end

  assign cb_y = luma_r.comb ? 8'((9'(pk_y) + 9'(prev_line)) >> 1) : pk_y;

  always_comb begin
    case (luma_r.core)
      2'h1: cr_y = (9'(cb_y) < `LPCS_CORE_N8) ? '0 : cb_y;
      2'h2: cr_y = (9'(cb_y) < `LPCS_CORE_N16) ? '0 : cb_y;
      2'h3: cr_y = (9'(cb_y) < `LPCS_CORE_N32) ? '0 : cb_y;
      default: cr_y = cb_y;
    endcase
  end

  always_comb begin
    if (luma_r.gamma && (fmt_r != lpcs_pkg::LPCS_FMT_YCRCB)) begin
      gm_y = pal_r ? gam(cr_y, `LPCS_GAMMA28) : gam(cr_y, `LPCS_GAMMA22);
    end else begin
      gm_y = cr_y;
    end
  end

  assign keep = (st_r == lpcs_pkg::LPCS_ST_RUN) && cap_act_r && (col_r >= crop_r);
  assign pix.fmt = fmt_r;
  assign pix.line_first = (col_r == crop_r);
  assign pix.luma = gm_y;

  // previous line store for the comb
  lpcs_linemem #(
    .AW(`LPCS_COL_W),
    .DW(8)
  ) u_line (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(acc),
    .waddr(col_r),
    .wdata(vid_luma),
    .raddr(raddr),
    .rdata(prev_line)
  );

  // output buffer, stalls the source when full
  lpcs_fifo #(
    .W($bits(lpcs_pkg::lpcs_pix_s)),
    .DEPTH(4)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(vid_valid && keep),
    .in_ready(fifo_in_ready),
    .in_data(pix),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_pixel),
    .level(fifo_level)
  );
endmodule // lpcs_luma_capture

// ===== lpcs_params.svh
// named constants of the luma processing and capture setup block
// assumes inclusion by bare name from every design file that needs it
`ifndef LPCS_PARAMS_SVH
`define LPCS_PARAMS_SVH
// register byte offsets
`define LPCS_A_LUMA 8'h00
`define LPCS_A_FMT 8'h04
`define LPCS_A_CROP 8'h08
`define LPCS_A_CAP 8'h0C
`define LPCS_A_WIDTH 8'h10
`define LPCS_A_STAT 8'h14
// axi responses
`define LPCS_RESP_OK 2'h0
`define LPCS_RESP_ERR 2'h2
// field widths
`define LPCS_LUMA_W 10
`define LPCS_COL_W 10
`define LPCS_WID_W 11
// crop origin snapping, positions are multiples of four
`define LPCS_CROP_HALF 17'h0_0002
`define LPCS_CROP_MAX 17'h0_03FC
`define LPCS_CROP_MASK 17'h1_FFFC
// auto lowpass width thresholds
`define LPCS_AUTO_W1 11'h280
`define LPCS_AUTO_W2 11'h140
`define LPCS_AUTO_W3 11'h0A0
// coring thresholds, n of 256
`define LPCS_CORE_N8 9'h008
`define LPCS_CORE_N16 9'h010
`define LPCS_CORE_N32 9'h020
// gamma knots at 0,32,..,224,255, entry zero lowest
`define LPCS_GAMMA22 72'hFF_F0_E0_CE_BA_A4_88_63_00
`define LPCS_GAMMA28 72'hFF_F3_E6_D8_C7_B4_9C_7A_00
// clamp limits
`define LPCS_LUMA_MAX 10'h0FF
`endif

// ===== lpcs_pkg.sv
// types of the luma processing and capture setup block
// assumes nothing beyond a tool that reads packages
package lpcs_pkg;
  // settling state, one-hot
  typedef enum logic [2:0] {
    LPCS_ST_RUN = 3'h1,
    LPCS_ST_ALIGN = 3'h2,
    LPCS_ST_SETTLE = 3'h4
  } lpcs_st_e;
  // pixel formats
  typedef enum logic [1:0] {
    LPCS_FMT_RGB32 = 2'h0,
    LPCS_FMT_RGB24 = 2'h1,
    LPCS_FMT_RGB16 = 2'h2,
    LPCS_FMT_YCRCB = 2'h3
  } lpcs_fmt_e;
  // lowpass codes, one of three levels, none or auto
  typedef enum logic [2:0] {
    LPCS_LP_NONE = 3'h0,
    LPCS_LP_L1 = 3'h1,
    LPCS_LP_L2 = 3'h2,
    LPCS_LP_L3 = 3'h3,
    LPCS_LP_AUTO = 3'h4
  } lpcs_lp_e;
  // sharpening codes, none or level0..level3
  typedef enum logic [2:0] {
    LPCS_PK_NONE = 3'h0,
    LPCS_PK_L0 = 3'h1,
    LPCS_PK_L1 = 3'h2,
    LPCS_PK_L2 = 3'h3,
    LPCS_PK_L3 = 3'h4
  } lpcs_pk_e;
  // luma control fields
  typedef struct packed {
    logic [2:0] peak;
    logic comb;
    logic gamma;
    logic [1:0] core;
    logic [2:0] lp;
  } lpcs_luma_s;
  // processed pixel
  typedef struct packed {
    logic [1:0] fmt;
    logic line_first;
    logic [7:0] luma;
  } lpcs_pix_s;
endpackage

// ===== lpcs_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active low reset
`timescale 1ns/10ps
module lpcs_fifo #(
  parameter int W = 11,
  parameter int DEPTH = 4
) (
  input logic aclk,
  input logic aresetn,
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];  // storage words
  logic [PW-1:0] wp_r;  // write pointer
  logic [PW-1:0] rp_r;  // read pointer
  logic [PW:0] cnt_r;  // fill count
  logic push;
  logic pop;
  // room while fewer than depth words are held
  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp_r];
  assign level = cnt_r;
  // storage write
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  // pointers, wrap at depth
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
      end
    end
  end
  // fill count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else if (push && !pop) begin
      cnt_r <= cnt_r + (PW+1)'(1);
    end else if (pop && !push) begin
      cnt_r <= cnt_r - (PW+1)'(1);
    end
  end
endmodule // lpcs_fifo

// ===== lpcs_linemem.sv
// one video line of luma, registered read
// assumes write and read addresses stable around the clock edge
`timescale 1ns/10ps
module lpcs_linemem #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  input logic aclk,
  input logic aresetn,
  input logic we,
  input logic [AW-1:0] waddr,
  input logic [DW-1:0] wdata,
  input logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];  // line store
  // write port
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  // registered read port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // lpcs_linemem

// ===== lpcs_video_src.sv
// pixel source model: fields of lines of pixels at one luma level
// assumes a sync active low reset and a sink that may stall
`timescale 1ns/10ps
module lpcs_video_src #(
  parameter int LINES = 2,
  parameter int PIX = 8
) (
  input logic aclk,
  input logic aresetn,
  input logic vid_ready,
  input logic [7:0] level,
  output logic vid_valid,
  output logic [7:0] vid_luma,
  output logic vid_line_start,
  output logic vid_field_start
);
  // free-running field loop, pulses between pixels
  initial begin
    vid_valid = 1'b0;
    vid_luma = 8'h00;
    vid_line_start = 1'b0;
    vid_field_start = 1'b0;
    forever begin
      @(posedge aclk iff aresetn);
      vid_field_start <= 1'b1;
      @(posedge aclk);
      vid_field_start <= 1'b0;
      for (int l = 0; l < LINES; l++) begin
        vid_line_start <= 1'b1;
        @(posedge aclk);
        vid_line_start <= 1'b0;
        @(posedge aclk);
        // each pixel held until taken
        for (int p = 0; p < PIX; p++) begin
          vid_valid <= 1'b1;
          vid_luma <= level;
          @(posedge aclk iff vid_ready);
        end
        vid_valid <= 1'b0;
        // no stale value once released
        vid_luma <= ~level;
      end
    end
  end
endmodule // lpcs_video_src

// ===== lpcs_luma_capture_checker.sv
// handshake and readback checks of the luma capture block
// assumes binding to the top module ports
`timescale 1ns/10ps
module lpcs_luma_capture_checker (
  input logic aclk,
  input logic aresetn,
  input logic s_awvalid,
  input logic s_awready,
  input logic s_wvalid,
  input logic s_wready,
  input logic s_bvalid,
  input logic s_bready,
  input logic [1:0] s_bresp,
  input logic s_arvalid,
  input logic s_arready,
  input logic [7:0] s_araddr,
  input logic s_rvalid,
  input logic s_rready,
  input logic [31:0] s_rdata,
  input logic [1:0] s_rresp,
  input logic vid_ready,
  input logic out_valid,
  input logic out_ready,
  input lpcs_pkg::lpcs_pix_s out_pixel
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answer soon after both write halves
  property p_wr_ans;
    s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
  property p_b_hold;
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_ans;
    s_arvalid && s_arready |=> s_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_r_hold;
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_unmap;
    s_arvalid && s_arready && s_araddr > 8'h17 |=> s_rresp == 2'h2 && s_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_crop;
    s_arvalid && s_arready && s_araddr == 8'h08 |=> s_rdata[1:0] == 2'h0 && s_rdata <= 32'h3FC;
  endproperty
  a_crop: assert property (p_crop) else $error("crop not snapped");
  property p_luma;
    s_arvalid && s_arready && s_araddr == 8'h00 |=> s_rdata[31:10] == 22'h0;
  endproperty
  a_luma: assert property (p_luma) else $error("luma field width");
  property p_o_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_pixel);
  endproperty
  a_o_hold: assert property (p_o_hold) else $error("pixel dropped");
  // main scenarios reached
  c_wr: cover property (s_bvalid && s_bready);
  c_err: cover property (s_rvalid && s_rresp == 2'h2);
  c_full: cover property (!vid_ready);
endmodule // lpcs_luma_capture_checker

bind lpcs_luma_capture lpcs_luma_capture_checker i_chk (.aclk, .aresetn, .s_awvalid,
  .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_bready, .s_bresp, .s_arvalid,
  .s_arready, .s_araddr, .s_rvalid, .s_rready, .s_rdata, .s_rresp, .vid_ready,
  .out_valid, .out_ready, .out_pixel);

// ===== tb_top.sv
// self-checking bench of the luma capture block over axi4-lite
// assumes the source model and the checker bind are compiled first
`timescale 1ns/10ps
`include "lpcs_params.svh"
module tb_top;
  localparam logic [71:0] G22 = `LPCS_GAMMA22;
  localparam logic [71:0] G28 = `LPCS_GAMMA28;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, out_valid, out_ready;
  logic vid_valid, vid_ready, vid_line_start, vid_field_start;
  logic [7:0] s_awaddr, s_araddr, src_luma, vid_luma;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  lpcs_pkg::lpcs_pix_s out_pixel;
  logic [9:0] exp_pix; // expected format and luma
  int error_cnt, cmp_count, pix_cnt, fld_cnt, first_fld, f0, cyc;
  int lw = 8; // kept pixels per line
  int crq[3] = '{5, 6, 1023};
  int cap[3] = '{4, 8, 1020};

  lpcs_luma_capture i_dut (.aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid,
    .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready,
    .s_araddr, .s_rvalid, .s_rready, .s_rdata, .s_rresp, .vid_valid, .vid_ready, .vid_luma,
    .vid_line_start, .vid_field_start, .out_valid, .out_ready, .out_pixel);
  lpcs_video_src #(.LINES(2), .PIX(8)) i_src (.aclk, .aresetn, .vid_ready,
    .level(src_luma), .vid_valid, .vid_luma, .vid_line_start, .vid_field_start);

  // clock
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // axi4-lite write, both halves offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_awvalid <= 1'b1;
    s_awaddr <= a;
    s_wvalid <= 1'b1;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_bready <= 1'b1;
    fork
      begin @(posedge aclk iff s_awready); s_awvalid <= 1'b0; end
      begin @(posedge aclk iff s_wready); s_wvalid <= 1'b0; end
    join
    @(posedge aclk iff s_bvalid);
    chk({30'h0, s_bresp}, {30'h0, r});
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // axi4-lite read with expected word and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    s_arvalid <= 1'b1;
    s_araddr <= a;
    s_rready <= 1'b1;
    @(posedge aclk iff s_arready);
    s_arvalid <= 1'b0;
    @(posedge aclk iff s_rvalid);
    chk(s_rdata, e);
    chk({30'h0, s_rresp}, {30'h0, r});
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // capture request just after a field boundary
  task automatic cap_go(input logic [1:0] f, input logic [31:0] st);
    @(posedge aclk iff vid_field_start);
    pix_cnt = 0;
    wr(`LPCS_A_CAP, {30'h0, f}, 2'h0);
    rd(`LPCS_A_STAT, st, 2'h0);
    f0 = fld_cnt;
  endtask

  // pixel count and fields waited before the first pixel
  task automatic cap_end(input int nf, input int np);
    wait (pix_cnt == np);
    repeat (40) @(posedge aclk);
    chk(pix_cnt, np);
    chk(first_fld - f0, nf);
  endtask

  // field counter, output monitor and hang limit
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (vid_field_start) fld_cnt <= fld_cnt + 1;
    if (out_valid && out_ready) begin
      if (pix_cnt == 0) first_fld = fld_cnt;
      chk({21'h0, out_pixel}, {21'h0, exp_pix[9:8], (pix_cnt % lw == 0), exp_pix[7:0]});
      pix_cnt = pix_cnt + 1;
    end
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    {error_cnt, cmp_count, pix_cnt, fld_cnt, first_fld, f0, cyc} = '0;
    out_ready = 1'b1;
    src_luma = 8'h20;
    exp_pix = {2'h0, 8'h20};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) rd(8'(4 * i), (i == 4) ? 32'h280 : 32'h0, 2'h0);
    wr(`LPCS_A_LUMA, 32'h1EB, 2'h0);
    rd(`LPCS_A_LUMA, 32'h1EB, 2'h0);
    wr(8'h18, 32'h0, 2'h2);
    rd(8'h18, 32'h0, 2'h2);
    for (int i = 0; i < 3; i++) begin
      wr(`LPCS_A_CROP, crq[i], 2'h0);
      rd(`LPCS_A_CROP, cap[i], 2'h0);
    end
    wr(`LPCS_A_CROP, 32'h0, 2'h0);
    wr(`LPCS_A_LUMA, 32'h0, 2'h0);
    cap_go(2'h0, 32'h2);
    cap_end(1, 16);
    // gamma on rgb, ntsc then pal
    wr(`LPCS_A_LUMA, 32'h20, 2'h0);
    exp_pix = {2'h0, G22[15:8]};
    cap_go(2'h0, 32'h2);
    cap_end(1, 16);
    wr(`LPCS_A_FMT, 32'h4, 2'h0);
    exp_pix = {2'h0, G28[15:8]};
    cap_go(2'h0, 32'h2);
    cap_end(1, 16);
    // capture in ycrcb switches format, settles, no gamma
    exp_pix = {2'h3, 8'h20};
    cap_go(2'h3, 32'h3);
    cap_end(2, 16);
    // preset format back, then coring at the threshold
    @(posedge aclk iff vid_field_start);
    wr(`LPCS_A_FMT, 32'h0, 2'h0);
    wr(`LPCS_A_LUMA, 32'h10, 2'h0);
    src_luma <= 8'h0F;
    exp_pix = {2'h0, 8'h00};
    cap_go(2'h0, 32'h3);
    cap_end(1, 16);
    src_luma <= 8'h10;
    exp_pix = {2'h0, 8'h10};
    cap_go(2'h0, 32'h2);
    cap_end(1, 16);
    // crop 4, peaking, comb, coring and auto lowpass (none at width 640) on a flat field, sink stalled until full
    wr(`LPCS_A_CROP, 32'h4, 2'h0);
    wr(`LPCS_A_LUMA, 32'hD4, 2'h0);
    lw = 4;
    out_ready <= 1'b0;
    cap_go(2'h0, 32'h2);
    wait (!vid_ready);
    rd(`LPCS_A_STAT, 32'h24, 2'h0);
    out_ready <= 1'b1;
    cap_end(1, 8);
    final_report();
  end
endmodule // tb_top
